// ---- rtl/tpf_pkg.sv ----
// Shared constants for the three-phase firing sequencer.
// Assumes one 20 MHz system clock and a pin-level speed oscillator input.
package tpf_pkg;
   localparam int          TPF_CLK_HZ       = 20000000;
   localparam int          TPF_DIV_WIDE     = 16;
   localparam int          TPF_DIV_NARROW   = 8;
   localparam int          TPF_STEPS        = 6;
   localparam logic [2:0]  TPF_STEP_LAST    = 3'h5;
   localparam logic [2:0]  TPF_STEP_HALF    = 3'h3;
   localparam logic [4:0]  TPF_DIVCNT_ZERO  = 5'h00;
   localparam logic [2:0]  TPF_STEP_ZERO    = 3'h0;
   // Firing train pulse period and low width, in ns
   localparam int          TPF_FT_PERIOD_NS = 10000;
   localparam int          TPF_FT_LOW_NS    = 1000;
   localparam int          TPF_FT_PERIOD_CYC = (TPF_FT_PERIOD_NS * (TPF_CLK_HZ / 1000000)) / 1000;
   localparam int          TPF_FT_LOW_CYC   = (TPF_FT_LOW_NS * (TPF_CLK_HZ / 1000000) + 999) / 1000;
   localparam logic [7:0]  TPF_FT_PERIOD_M1 = 8'(TPF_FT_PERIOD_CYC - 1);
   localparam logic [7:0]  TPF_FT_LOW_M1    = 8'(TPF_FT_LOW_CYC - 1);
   localparam logic [7:0]  TPF_FT_ZERO      = 8'h00;
   // Fire index per phase: 0 main upper, 1 main lower, 2 comm upper, 3 comm lower
   localparam int          TPF_SCR_PER_PH   = 4;
   typedef enum logic [1:0] {
      TPF_ST_IDLE  = 2'b00,
      TPF_ST_RUN   = 2'b01,
      TPF_ST_TRIP  = 2'b10,
      TPF_ST_OCL   = 2'b11
   } tpf_state_e;
endpackage

// ---- rtl/tpf_sequencer.sv ----
// Three-phase firing sequencer: divides the speed oscillator, builds six-step
// phases, swaps B/C on reverse, chops centre portions, and gates firing.
// Assumes chopping, trips and controls are asynchronous pins; one system clock.
`timescale 1ns/100ps
module tpf_sequencer
(
   input  wire logic              mclk_in,
   input  wire logic              resetn_in,
   input  wire logic              speed_oscillator_in,
   input  wire logic              narrow_divider_variant_in,
   input  wire logic              reverse_in,
   input  wire logic              start_n_in,
   input  wire logic              chop_in,
   input  wire logic              min_voltage_in,
   input  wire logic              volt_trip_in,
   input  wire logic              instant_overcurrent_in,
   output logic [2:0]             phase_out,
   output logic [2:0]             phase_inv_out,
   output logic [11:0]            scr_fire_out,
   output logic [2:0]             commutation_trip_out,
   output logic                   freq_feedback_out,
   output logic                   min_voltage_flag_n_out,
   output logic                   firing_train_n_out,
   output logic                   ready_run_n_out
);
   import tpf_pkg::*;

   logic              rst_m_r;
   logic              rst_n_r;
   logic [5:0]        sync_m_r;
   logic [5:0]        sync_a_r;
   logic [5:0]        sync_b_r;
   logic [5:0]        clean_r;
   logic              narrow_r;
   logic              strap_done_r;
   logic [4:0]        div_cnt_r;
   logic [2:0]        step_r;
   logic [2:0]        step_nxt;
   logic              step_tick;
   logic [7:0]        ft_cnt_r;
   tpf_state_e        state_r;
   logic [2:0]        sq;
   logic [2:0]        abc;
   logic              osc_rise;
   logic [6:0]        sync_in;

   // Reset release through two flip-flops
   always_ff @(posedge mclk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         rst_m_r <= 1'b0;
         rst_n_r <= 1'b0;
      end
      else
      begin
         rst_m_r <= 1'b1;
         rst_n_r <= rst_m_r;
      end
   end

   assign sync_in = {speed_oscillator_in, reverse_in, start_n_in, chop_in,
                     min_voltage_in, volt_trip_in, instant_overcurrent_in};

   // Three-stage synchronisers; a change counts when stages two and three agree
   // Start is active low, so its stages reset high to avoid a false start request
   always_ff @(posedge mclk_in or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         sync_m_r <= 6'h10;
         sync_a_r <= 6'h10;
         sync_b_r <= 6'h10;
         clean_r  <= 6'h10;
      end
      else
      begin
         sync_m_r <= sync_in[5:0];
         sync_a_r <= sync_m_r;
         sync_b_r <= sync_a_r;
         for (int i = 0; i < 6; i++)
         begin
            if (sync_a_r[i] == sync_b_r[i])
               clean_r[i] <= sync_b_r[i];
         end
      end
   end

   logic [2:0] osc_sync_r;
   logic       osc_clean_r;
   always_ff @(posedge mclk_in or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         osc_sync_r  <= 3'h0;
         osc_clean_r <= 1'b0;
      end
      else
      begin
         osc_sync_r <= {osc_sync_r[1:0], sync_in[6]};
         if (osc_sync_r[1] == osc_sync_r[2])
            osc_clean_r <= osc_sync_r[2];
      end
   end

   wire rev_c  = clean_r[5];
   wire strt_n = clean_r[4];
   wire chop_c = clean_r[3];
   wire minv_c = clean_r[2];
   wire vtrp_c = clean_r[1];
   wire ioc_c  = clean_r[0];

   logic osc_q_r;
   always_ff @(posedge mclk_in or negedge rst_n_r)
   begin
      if (!rst_n_r)
         osc_q_r <= 1'b0;
      else
         osc_q_r <= osc_clean_r;
   end
   assign osc_rise = osc_clean_r & ~osc_q_r;

   // strap caught once after reset release
   always_ff @(posedge mclk_in or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         narrow_r     <= 1'b0;
         strap_done_r <= 1'b0;
      end
      else if (!strap_done_r)
      begin
         narrow_r     <= narrow_divider_variant_in;
         strap_done_r <= 1'b1;
      end
   end

   function automatic logic [4:0] div_last(input logic nar);
      div_last = nar ? 5'(TPF_DIV_NARROW - 1) : 5'(TPF_DIV_WIDE - 1);
   endfunction

   always_ff @(posedge mclk_in or negedge rst_n_r)
   begin
      if (!rst_n_r)
         div_cnt_r <= TPF_DIVCNT_ZERO;
      else if (osc_rise)
      begin
         if (div_cnt_r >= div_last(narrow_r))
            div_cnt_r <= TPF_DIVCNT_ZERO;
         else
            div_cnt_r <= div_cnt_r + 5'h01;
      end
   end
   assign step_tick = osc_rise && (div_cnt_r >= div_last(narrow_r));

   always_comb
   begin
      step_nxt = step_r;
      if (step_tick)
         step_nxt = (step_r == TPF_STEP_LAST) ? TPF_STEP_ZERO : step_r + 3'h1;
   end
   always_ff @(posedge mclk_in or negedge rst_n_r)
   begin
      if (!rst_n_r)
         step_r <= TPF_STEP_ZERO;
      else
         step_r <= step_nxt;
   end

   function automatic logic six_step(input logic [2:0] s, input logic [2:0] ofs);
      logic [3:0] t;
      t = {1'b0, s} + {1'b0, ofs};
      if (t > {1'b0, TPF_STEP_LAST})
         t = t - 4'(TPF_STEPS);
      six_step = (t[2:0] < TPF_STEP_HALF);
   endfunction

   // X, Y, Z square waves spaced two steps apart
   always_comb
   begin
      sq[0] = six_step(step_r, 3'h0);
      sq[1] = six_step(step_r, 3'h4);
      sq[2] = six_step(step_r, 3'h2);
   end

   // phase routing; reverse swaps Y and Z onto B and C
   always_comb
   begin
      abc[0] = sq[0];
      abc[1] = rev_c ? sq[2] : sq[1];
      abc[2] = rev_c ? sq[1] : sq[2];
   end

   // Middle step of either half cycle for a phase with the given offset
   function automatic logic is_centre(input logic [2:0] s, input logic [2:0] ofs);
      logic [3:0] t;
      t = {1'b0, s} + {1'b0, ofs};
      if (t > {1'b0, TPF_STEP_LAST})
         t = t - 4'(TPF_STEPS);
      is_centre = (t[2:0] == 3'h1) || (t[2:0] == (3'h1 + TPF_STEP_HALF));
   endfunction

   // centre step follows the routed phase, so reverse moves it too
   logic [2:0] mid;
   always_comb
   begin
      mid[0] = is_centre(step_r, 3'h0);
      mid[1] = rev_c ? is_centre(step_r, 3'h2) : is_centre(step_r, 3'h4);
      mid[2] = rev_c ? is_centre(step_r, 3'h4) : is_centre(step_r, 3'h2);
   end

   // Protection state machine
   always_ff @(posedge mclk_in or negedge rst_n_r)
   begin
      if (!rst_n_r)
         state_r <= TPF_ST_IDLE;
      else
      begin
         unique case (state_r)
            TPF_ST_IDLE: if (!strt_n && !vtrp_c && !ioc_c) state_r <= TPF_ST_RUN;
            TPF_ST_RUN:  if (ioc_c) state_r <= TPF_ST_OCL;
                         else if (vtrp_c) state_r <= TPF_ST_TRIP;
                         else if (strt_n) state_r <= TPF_ST_IDLE;
            TPF_ST_TRIP: if (ioc_c) state_r <= TPF_ST_OCL;
                         else if (strt_n && !vtrp_c) state_r <= TPF_ST_IDLE;
            // Lockout held until start is released and overcurrent has cleared
            TPF_ST_OCL:  if (strt_n && !ioc_c) state_r <= TPF_ST_IDLE;
         endcase
      end
   end

   // Firing train timer
   always_ff @(posedge mclk_in or negedge rst_n_r)
   begin
      if (!rst_n_r)
         ft_cnt_r <= TPF_FT_ZERO;
      else if (ft_cnt_r >= TPF_FT_PERIOD_M1)
         ft_cnt_r <= TPF_FT_ZERO;
      else
         ft_cnt_r <= ft_cnt_r + 8'h01;
   end

   // Registered outputs
   always_ff @(posedge mclk_in or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         phase_out              <= 3'h0;
         phase_inv_out          <= 3'h0;
         scr_fire_out           <= 12'h000;
         commutation_trip_out   <= 3'h0;
         freq_feedback_out      <= 1'b0;
         min_voltage_flag_n_out <= 1'b1;
         firing_train_n_out     <= 1'b1;
         ready_run_n_out        <= 1'b1;
      end
      else
      begin
         for (int p = 0; p < 3; p++)
         begin
            // centre step of each half cycle follows the chop
            logic pm;
            logic im;
            pm = mid[p] ? (abc[p] & chop_c) : abc[p];
            im = mid[p] ? (~abc[p] & chop_c) : ~abc[p];
            phase_out[p]     <= pm;
            phase_inv_out[p] <= im;
            // main and commutating thyristors per phase
            if (state_r == TPF_ST_OCL)
               scr_fire_out[p*TPF_SCR_PER_PH +: TPF_SCR_PER_PH] <= 4'h3;
            else if (state_r == TPF_ST_RUN)
               scr_fire_out[p*TPF_SCR_PER_PH +: TPF_SCR_PER_PH] <=
                  {~abc[p] & ~im, abc[p] & ~pm, ~pm, pm};
            else
               scr_fire_out[p*TPF_SCR_PER_PH +: TPF_SCR_PER_PH] <= 4'h0;
         end
         commutation_trip_out <= (state_r == TPF_ST_TRIP) ? 3'h7 : 3'h0;
         if (osc_rise)
            freq_feedback_out <= ~freq_feedback_out;
         min_voltage_flag_n_out <= ~minv_c;
         firing_train_n_out <= ~((state_r == TPF_ST_RUN) && (ft_cnt_r <= TPF_FT_LOW_M1));
         // low while the state machine is in run; minimum voltage is not considered
         ready_run_n_out <= ~(state_r == TPF_ST_RUN);
      end
   end

   chk_trip_all: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
      (state_r == TPF_ST_TRIP) |=> (commutation_trip_out == 3'h7))
      else $error("trip not sent to every phase");
   chk_ocl_fire: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
      (state_r == TPF_ST_OCL) |=> (scr_fire_out == 12'h333))
      else $error("overcurrent did not fire all mains");
   chk_ioc_entry: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
      (state_r == TPF_ST_RUN && ioc_c) |=> (state_r == TPF_ST_OCL))
      else $error("overcurrent not latched");
   chk_step_wrap: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
      (step_r == TPF_STEP_LAST && step_tick) |=> (step_r == TPF_STEP_ZERO))
      else $error("six step wrap wrong");
   chk_div_ratio: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
      step_tick |-> (div_cnt_r == div_last(narrow_r)))
      else $error("divider ratio wrong");
   chk_fb_toggle: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
      osc_rise |=> (freq_feedback_out != $past(freq_feedback_out)))
      else $error("feedback did not toggle");
   chk_phase_a: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
      (!mid[0]) |=> (phase_out[0] == $past(sq[0])))
      else $error("phase A does not follow X");
   chk_rev_swap: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
      (rev_c && !mid[1]) |=> (phase_out[1] == $past(sq[2])))
      else $error("reverse swap missing");
   chk_minv_flag: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
      minv_c |=> !min_voltage_flag_n_out)
      else $error("min voltage flag not low");
   chk_ready_low: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
      (state_r == TPF_ST_RUN) |=> !ready_run_n_out)
      else $error("ready not low while running");
   chk_strap_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
      strap_done_r |=> $stable(narrow_r))
      else $error("divider strap changed");
   chk_train_idle: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
      (state_r != TPF_ST_RUN) |=> firing_train_n_out)
      else $error("firing train pulsed while not running");

   cov_run:   cover property (@(posedge mclk_in) disable iff (!rst_n_r) state_r == TPF_ST_RUN);
   cov_trip:  cover property (@(posedge mclk_in) disable iff (!rst_n_r) state_r == TPF_ST_TRIP);
   cov_ocl:   cover property (@(posedge mclk_in) disable iff (!rst_n_r) state_r == TPF_ST_OCL);
   cov_rev:   cover property (@(posedge mclk_in) disable iff (!rst_n_r) rev_c && step_tick);
endmodule

// ---- tb/tpf_gate_amp_model.sv ----
// Gate pulse amplifier model: main fire bits set the power leg level per phase.
// Assumes fire bits are registered levels in the system clock domain.
`timescale 1ns/100ps
module tpf_gate_amp_model
(
   input  wire logic        mclk_in,
   input  wire logic        resetn_in,
   input  wire logic [11:0] scr_fire_in,
   output logic [2:0]       power_phase_out
);
   always_ff @(posedge mclk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         power_phase_out <= 3'h0;
      end
      else
      begin
         for (int p = 0; p < 3; p++)
         begin
            // Both mains on is the overcurrent clamp; the leg level then keeps its value
            if (scr_fire_in[4*p] && !scr_fire_in[4*p+1])
               power_phase_out[p] <= 1'b1;
            else if (scr_fire_in[4*p+1] && !scr_fire_in[4*p])
               power_phase_out[p] <= 1'b0;
         end
      end
   end
endmodule

// ---- tb/three_phase_firing_sequencer_test.sv ----
// Self-checking bench for the firing sequencer with a gate amplifier model.
// Assumes async pins are given at least 6 clocks per level to pass the filters.
`timescale 1ns/100ps
module three_phase_firing_sequencer_test;
   import tpf_pkg::*;
   logic        mclk_in, resetn_in, osc, narrow, rev, start_n, chop, minv, vtrip, ocur;
   logic [2:0]  ph, ph_inv, ctrip, power;
   logic [11:0] fire;
   logic        ffb, minv_n, ft_n, ready_n;
   int          failures, n_checks, rises, step, n, m;

   tpf_sequencer u_tpf_sequencer (.mclk_in(mclk_in), .resetn_in(resetn_in),
      .speed_oscillator_in(osc), .narrow_divider_variant_in(narrow), .reverse_in(rev),
      .start_n_in(start_n), .chop_in(chop), .min_voltage_in(minv), .volt_trip_in(vtrip),
      .instant_overcurrent_in(ocur), .phase_out(ph), .phase_inv_out(ph_inv),
      .scr_fire_out(fire), .commutation_trip_out(ctrip), .freq_feedback_out(ffb),
      .min_voltage_flag_n_out(minv_n), .firing_train_n_out(ft_n), .ready_run_n_out(ready_n));
   tpf_gate_amp_model u_tpf_gate_amp_model (.mclk_in(mclk_in), .resetn_in(resetn_in),
      .scr_fire_in(fire), .power_phase_out(power));

   initial
   begin
      mclk_in = 1'b0;
      forever #25 mclk_in = ~mclk_in;
   end

   task automatic tick(input int k);
      repeat (k) @(negedge mclk_in);
   endtask

   task automatic cmp_vec(input logic [11:0] got, input logic [11:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Expected {inverses, phases}: B starts at step 2, C at step 4; reverse swaps B and C
   function automatic logic [5:0] exp_ph(input int s, input logic r, input logic c);
      logic [5:0] e;
      int         d;
      for (int p = 0; p < 3; p++)
      begin
         d = (s - ((p == 0) ? 0 : (((p == 1) ^ r) ? 2 : 4)) + 6) % 6;
         e[p] = (d < 3) && !(d == 1 && !c);
         e[p+3] = (d >= 3) && !(d == 4 && !c);
      end
      return e;
   endfunction

   task automatic do_reset(input logic strap);
      resetn_in = 1'b0;
      start_n = 1'b1;
      narrow = strap;
      tick(20);
      cmp_vec(fire, 12'h000);
      cmp_vec({2'h0, ph_inv, ph, ctrip, ffb}, 12'h000);
      cmp_vec({9'h000, minv_n, ft_n, ready_n}, 12'h007);
      resetn_in = 1'b1;
      tick(5);
      rises = 0;
      step = 0;
   endtask

   task automatic pulses(input int k);
      repeat (k)
      begin
         osc = 1'b1;
         tick(6);
         osc = 1'b0;
         tick(6);
         rises++;
      end
      tick(4);
   endtask

   task automatic check_step();
      logic [5:0] e;
      e = exp_ph(step, rev, chop);
      cmp_vec({6'h00, ph_inv, ph}, {6'h00, e});
      cmp_vec({9'h000, power}, {9'h000, e[2:0]});
      cmp_vec({11'h000, ffb}, {11'h000, rises[0]});
   endtask

   task automatic walk(input int div);
      int r0;
      r0 = rises;
      repeat (6)
      begin
         pulses(div - 1);
         check_step();
         pulses(1);
         step = (step + 1) % 6;
         check_step();
      end
      // Feedback periods per fundamental set the external reference multiple
      cmp_vec(12'((rises - r0) / 2), (div == TPF_DIV_WIDE) ? 12'd48 : 12'd24);
   endtask

   task automatic run_up();
      start_n = 1'b1;
      tick(10);
      start_n = 1'b0;
      tick(10);
      cmp_vec({11'h000, ready_n}, 12'h000);
   endtask

   initial
   begin
      {resetn_in, osc, narrow, rev, start_n, minv, vtrip, ocur} = 8'h08;
      chop = 1'b1;
      failures = 0;
      n_checks = 0;
      do_reset(1'b0);
      run_up();
      walk(16);
      rev = 1'b1;
      tick(10);
      walk(16);
      $display("test divide and reverse done");
      {rev, chop} = 2'b00;
      tick(10);
      walk(16);
      chop = 1'b1;
      $display("test chopping done");
      n = 0;
      while (ft_n !== 1'b0 && n < 400)
      begin
         tick(1);
         n++;
      end
      n = 0;
      while (ft_n === 1'b0 && n < 400)
      begin
         tick(1);
         n++;
      end
      m = 0;
      while (ft_n !== 1'b0 && m < 400)
      begin
         tick(1);
         m++;
      end
      cmp_vec(12'(n), 12'(TPF_FT_LOW_CYC));
      cmp_vec(12'(n + m), 12'(TPF_FT_PERIOD_CYC));
      minv = 1'b1;
      tick(10);
      cmp_vec({11'h000, minv_n}, 12'h000);
      minv = 1'b0;
      tick(10);
      cmp_vec({11'h000, minv_n}, 12'h001);
      $display("test train and flag done");
      vtrip = 1'b1;
      tick(10);
      cmp_vec({9'h000, ctrip}, 12'h007);
      cmp_vec(fire, 12'h000);
      vtrip = 1'b0;
      run_up();
      // Both faults at once: overcurrent wins
      {vtrip, ocur} = 2'b11;
      tick(10);
      cmp_vec(fire & 12'h333, 12'h333);
      {vtrip, ocur} = 2'b00;
      tick(10);
      cmp_vec({11'h000, ready_n}, 12'h001);
      run_up();
      $display("test protection done");
      do_reset(1'b1);
      narrow = 1'b0;
      run_up();
      walk(8);
      $display("test narrow divider done");
      wrap_up();
   end

   initial
   begin
      repeat (40000) @(posedge mclk_in);
      failures++;
      wrap_up();
   end
endmodule
